// >>> shared/iss_pkg.sv
/*
  constants, types and helpers of the interrupt source selector.
  assumes one 10 MHz clock, asynchronous active-low reset and an APB slave port.
*/
// What this block does
// - sixteen core interrupt lines, line 0 highest priority, line 15 lowest
// - lines 0 to 3 fixed: reset, non-maskable, two reserved; never remapped
// - lines 4 to 15 maskable, each fed through a 5-bit selector field
// - low selector holds lines 4-9 fields at 4:0,9:5,14:10,20:16,25:21,30:26
// - high selector holds lines 10-15, same positions, four bytes below low
// - reset codes: 04,05,06,07,08,09,03,0a,0b,00,01,02 for lines 4-15
// - codes 00-03 host,timers,memory; 04-07 pin irqs 4-7; 08 dma done
// - codes 09-0b emulation; 0c-0f serial ports; 10 combined gpio irq
// - codes 16,17 two-wire; 1c-1f audio ports; 11-15 and 18-1b reserved
// - pin irqs 4-7 are edge detected on pins 4-7, edge set per pin
// - gpio logic also controls pin irqs 4-7 beyond the polarity bits
// - all sixteen pins feed the combined irq; pins 4-7 may go dedicated
// - a source reaches the core only when selected by some line field
// - global enable gates lines 4-15, resets to zero
`default_nettype none
package iss_pkg;
  localparam logic [31:0] ADDR_SEL_HIGH   = 32'h019c_0000;
  localparam logic [31:0] ADDR_SEL_LOW    = 32'h019c_0004;
  localparam logic [31:0] ADDR_CTRL       = 32'h019c_0008;
  localparam logic [31:0] ADDR_GPIO_CFG   = 32'h019c_000c;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h019c_0010;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'h019c_0014;

  localparam int NUM_LINES   = 16;
  localparam int FIXED_LINES = 4;
  localparam int NUM_SEL     = 12;
  localparam int SEL_W       = 5;
  localparam int FIELDS_REG  = 6;
  localparam int SEL_LSB [FIELDS_REG] = '{0, 5, 10, 16, 21, 26};

  localparam logic [31:0] SEL_HIGH_RST = 32'h0820_2d43;
  localparam logic [31:0] SEL_LOW_RST  = 32'h2507_18a4;
  localparam logic [31:0] SEL_WMASK    = 32'h7fff_7fff;

  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_POL_LSB = 4;
  localparam int CTRL_DED_LSB = 8;
  localparam int GPIO_EN_LSB  = 0;
  localparam int GPIO_DIR_LSB = 16;
  localparam logic [3:0]  POL_RST  = 4'h0;
  localparam logic [3:0]  DED_RST  = 4'hf;
  localparam logic [15:0] GPIO_PIN_ENABLE_RST = 16'h0000;
  localparam logic [15:0] GPIO_PIN_DIRECTION_RST = 16'h0000;

  localparam logic [4:0] CODE_HOST   = 5'h00;
  localparam logic [4:0] CODE_TIMER0 = 5'h01;
  localparam logic [4:0] CODE_TIMER1 = 5'h02;
  localparam logic [4:0] CODE_MEMIF  = 5'h03;
  localparam logic [4:0] CODE_GP4    = 5'h04;
  localparam logic [4:0] CODE_DMA    = 5'h08;
  localparam logic [4:0] CODE_EMU_DT = 5'h09;
  localparam logic [4:0] CODE_EMU_RX = 5'h0a;
  localparam logic [4:0] CODE_EMU_TX = 5'h0b;
  localparam logic [4:0] CODE_BSP0_TX = 5'h0c;
  localparam logic [4:0] CODE_BSP0_RX = 5'h0d;
  localparam logic [4:0] CODE_BSP1_TX = 5'h0e;
  localparam logic [4:0] CODE_BSP1_RX = 5'h0f;
  localparam logic [4:0] CODE_GP0    = 5'h10;
  localparam logic [4:0] CODE_TW0    = 5'h16;
  localparam logic [4:0] CODE_TW1    = 5'h17;
  localparam logic [4:0] CODE_ASP0_TX = 5'h1c;
  localparam logic [4:0] CODE_ASP0_RX = 5'h1d;
  localparam logic [4:0] CODE_ASP1_TX = 5'h1e;
  localparam logic [4:0] CODE_ASP1_RX = 5'h1f;
  localparam logic [4:0] RSV_A_LO = 5'h11;
  localparam logic [4:0] RSV_A_HI = 5'h15;
  localparam logic [4:0] RSV_B_LO = 5'h18;
  localparam logic [4:0] RSV_B_HI = 5'h1b;

  typedef enum logic {
    APB_IDLE   = 1'b0,
    APB_ANSWER = 1'b1
  } iss_apb_state_t;

  function automatic logic iss_code_reserved(input logic [4:0] c);
    return ((c >= RSV_A_LO) && (c <= RSV_A_HI)) || ((c >= RSV_B_LO) && (c <= RSV_B_HI));
  endfunction : iss_code_reserved
endpackage : iss_pkg
`default_nettype wire

// >>> shared/iss_gpio_if.sv
/*
  carrier between the selector top and its gpio edge detector.
  assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface iss_gpio_if;
  logic [15:0] pins;
  logic [15:0] pin_en;
  logic [15:0] pin_dir;
  logic [3:0]  pol;
  logic [3:0]  ded;
  logic [3:0]  pin_irq;
  logic        combined_irq;

  modport edge_side (input pins, pin_en, pin_dir, pol, ded, output pin_irq, combined_irq);
  modport ctl_side (output pins, pin_en, pin_dir, pol, ded, input pin_irq, combined_irq);
endinterface : iss_gpio_if
`default_nettype wire

// >>> src/iss_gpio_edge.sv
/*
  edge detection of the gpio pins: dedicated pin irqs 4-7 and the combined irq.
  assumes pins synchronous to pclk; direction bit 1 means output.
*/
`timescale 1ns/1ps
`default_nettype none
module iss_gpio_edge
  import iss_pkg::*;
(
  // clock and reset
  input wire logic      pclk,
  input wire logic      presetn,
  // pins and configuration
  iss_gpio_if.edge_side gp
);
  typedef struct packed {
    logic [15:0] prev;
    logic [3:0]  pin_irq;
    logic        comb;
  } iss_edge_state_t;

  iss_edge_state_t q;
  iss_edge_state_t d;

  always_comb begin
    logic [15:0] live;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] to_comb;
    live = gp.pin_en & ~gp.pin_dir;
    rise = gp.pins & ~q.prev;
    fall = ~gp.pins & q.prev;
    to_comb = live & ~{8'h00, gp.ded, 4'h0};
    d = q;
    d.prev = gp.pins;
    for (int i = 0; i < 4; i++) begin
      // selected edge per pin, then routed only if dedicated
      d.pin_irq[i] = live[4 + i] & gp.ded[i] & (gp.pol[i] ? fall[4 + i] : rise[4 + i]);
    end
    d.comb = |(rise & to_comb);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign gp.pin_irq      = q.pin_irq;
  assign gp.combined_irq = q.comb;

  a_pin_edge_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (gp.pin_irq[0] && !$past(gp.pol[0])) |-> ($past(gp.pins[4]) && !$past(gp.pins[4], 2)))
    else $error("pin irq 4 without a rising edge");
  a_ded_blocks_comb: assert property (@(posedge pclk) disable iff (!presetn)
    (((gp.pins ^ $past(gp.pins)) == 16'h0010) && gp.ded[0]) |=> !gp.combined_irq)
    else $error("dedicated pin leaked into combined irq");
endmodule : iss_gpio_edge
`default_nettype wire

// >>> src/iss_top.sv
/*
  interrupt source selector: APB registers, 32-way source selection onto
  core lines 4-15, fixed lines 0-3, global enable, sticky status and irq.
  assumes event inputs and pins synchronous to pclk, APB3 master on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module iss_top
  import iss_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // fixed sources
  input  wire logic        reset_event,
  input  wire logic        nmi_event,
  // peripheral events
  input  wire logic        host_port_event,
  input  wire logic        timer0_event,
  input  wire logic        timer1_event,
  input  wire logic        memif_event,
  input  wire logic        dma_done_event,
  input  wire logic        emu_transfer_event,
  input  wire logic        emu_rx_event,
  input  wire logic        emu_tx_event,
  input  wire logic        bsp0_tx_event,
  input  wire logic        bsp0_rx_event,
  input  wire logic        bsp1_tx_event,
  input  wire logic        bsp1_rx_event,
  input  wire logic        twowire0_event,
  input  wire logic        twowire1_event,
  input  wire logic        asp0_tx_event,
  input  wire logic        asp0_rx_event,
  input  wire logic        asp1_tx_event,
  input  wire logic        asp1_rx_event,
  // gpio pins
  input  wire logic [15:0] gpio_pins,
  // core side
  output var  logic [15:0] core_irq,
  output var  logic        irq
);
  typedef struct packed {
    iss_apb_state_t ph;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic [31:0]    sel_hi;
    logic [31:0]    sel_lo;
    logic           global_irq_enable;
    logic [3:0]     pol;
    logic [3:0]     ded;
    logic [15:0]    gpio_pin_enable;
    logic [15:0]    gpio_pin_direction;
    logic [11:0]    status;
    logic [11:0]    mask;
    logic [15:0]    core_irq;
    logic           irq;
  } iss_top_state_t;

  localparam iss_top_state_t Q_RST = '{
    ph:       APB_IDLE,
    prdata:   32'h0000_0000,
    pready:   1'b0,
    pslverr:  1'b0,
    sel_hi:   SEL_HIGH_RST,
    sel_lo:   SEL_LOW_RST,
    global_irq_enable:      1'b0,
    pol:      POL_RST,
    ded:      DED_RST,
    gpio_pin_enable:     GPIO_PIN_ENABLE_RST,
    gpio_pin_direction:    GPIO_PIN_DIRECTION_RST,
    status:   12'h000,
    mask:     12'h000,
    core_irq: 16'h0000,
    irq:      1'b0
  };

  iss_top_state_t q;
  iss_top_state_t d;

  iss_gpio_if gp ();

  logic [31:0]             src;
  logic [NUM_SEL-1:0][4:0] sel_code;
  logic [NUM_SEL-1:0]      line_src;
  logic                    wr_take;
  logic [11:0]             clr;

  assign gp.pins    = gpio_pins;
  assign gp.pin_en  = q.gpio_pin_enable;
  assign gp.pin_dir = q.gpio_pin_direction;
  assign gp.pol     = q.pol;
  assign gp.ded     = q.ded;

  iss_gpio_edge iss_gpio_edge_i (
    .pclk    (pclk),
    .presetn (presetn),
    .gp      (gp)
  );

  // source table indexed by selector code; reserved codes stay zero
  always_comb begin
    src = 32'h0000_0000;
    src[CODE_HOST]    = host_port_event;
    src[CODE_TIMER0]  = timer0_event;
    src[CODE_TIMER1]  = timer1_event;
    src[CODE_MEMIF]   = memif_event;
    src[CODE_GP4 +: 4] = gp.pin_irq;
    src[CODE_DMA]     = dma_done_event;
    src[CODE_EMU_DT]  = emu_transfer_event;
    src[CODE_EMU_RX]  = emu_rx_event;
    src[CODE_EMU_TX]  = emu_tx_event;
    src[CODE_BSP0_TX] = bsp0_tx_event;
    src[CODE_BSP0_RX] = bsp0_rx_event;
    src[CODE_BSP1_TX] = bsp1_tx_event;
    src[CODE_BSP1_RX] = bsp1_rx_event;
    src[CODE_GP0]     = gp.combined_irq;
    src[CODE_TW0]     = twowire0_event;
    src[CODE_TW1]     = twowire1_event;
    src[CODE_ASP0_TX] = asp0_tx_event;
    src[CODE_ASP0_RX] = asp0_rx_event;
    src[CODE_ASP1_TX] = asp1_tx_event;
    src[CODE_ASP1_RX] = asp1_rx_event;
  end

  // one selector field per maskable line
  for (genvar k = 0; k < NUM_SEL; k++) begin : g_sel
    if (k < FIELDS_REG) begin : g_low
      assign sel_code[k] = q.sel_lo[SEL_LSB[k] +: SEL_W];
    end else begin : g_high
      assign sel_code[k] = q.sel_hi[SEL_LSB[k - FIELDS_REG] +: SEL_W];
    end
    assign line_src[k] = src[sel_code[k]];
  end

  assign wr_take = (q.ph == APB_ANSWER) && psel && penable && pwrite;
  assign clr     = (wr_take && paddr == ADDR_IRQ_STATUS) ? pwdata[11:0] : 12'h000;

  always_comb begin
    logic [31:0] rd;
    logic        hit;
    rd  = 32'h0000_0000;
    hit = 1'b1;
    d   = q;
    unique case (paddr)
      ADDR_SEL_HIGH:   rd = q.sel_hi;
      ADDR_SEL_LOW:    rd = q.sel_lo;
      ADDR_CTRL: begin
        rd[CTRL_GIE_BIT] = q.global_irq_enable;
        rd[CTRL_POL_LSB +: 4] = q.pol;
        rd[CTRL_DED_LSB +: 4] = q.ded;
      end
      ADDR_GPIO_CFG: begin
        rd[GPIO_EN_LSB +: 16]  = q.gpio_pin_enable;
        rd[GPIO_DIR_LSB +: 16] = q.gpio_pin_direction;
      end
      ADDR_IRQ_STATUS: rd[11:0] = q.status;
      ADDR_IRQ_MASK:   rd[11:0] = q.mask;
      default:         hit = 1'b0;
    endcase

    // apb: one wait state, answer in the second access cycle
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    unique case (q.ph)
      APB_IDLE: begin
        if (psel && penable) begin
          d.ph      = APB_ANSWER;
          d.pready  = 1'b1;
          d.pslverr = ~hit;
          d.prdata  = pwrite ? 32'h0000_0000 : rd;
        end
      end
      APB_ANSWER: begin
        d.ph = APB_IDLE;
      end
    endcase

    if (wr_take) begin
      unique case (paddr)
        ADDR_SEL_HIGH: d.sel_hi = pwdata & SEL_WMASK;
        ADDR_SEL_LOW:  d.sel_lo = pwdata & SEL_WMASK;
        ADDR_CTRL: begin
          d.global_irq_enable = pwdata[CTRL_GIE_BIT];
          d.pol = pwdata[CTRL_POL_LSB +: 4];
          d.ded = pwdata[CTRL_DED_LSB +: 4];
        end
        ADDR_GPIO_CFG: begin
          d.gpio_pin_enable  = pwdata[GPIO_EN_LSB +: 16];
          d.gpio_pin_direction = pwdata[GPIO_DIR_LSB +: 16];
        end
        ADDR_IRQ_MASK: d.mask = pwdata[11:0];
        default: ;
      endcase
    end

    // set beats clear on the same edge
    d.status = (q.status & ~clr) | line_src;

    d.core_irq[0] = reset_event;
    d.core_irq[1] = nmi_event;
    d.core_irq[FIXED_LINES-1:2] = 2'b00;
    d.core_irq[NUM_LINES-1:FIXED_LINES] = line_src & {NUM_SEL{q.global_irq_enable}};
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign core_irq = q.core_irq;
  assign irq      = q.irq;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  sequence s_write_hi;
    s_setup ##1 (s_access and (pwrite && paddr == ADDR_SEL_HIGH)) ##1 (s_access and pready);
  endsequence

  sequence s_write_lo;
    s_setup ##1 (s_access and (pwrite && paddr == ADDR_SEL_LOW)) ##1 (s_access and pready);
  endsequence

  sequence s_read_hi;
    s_setup ##1 (s_access and (!pwrite && paddr == ADDR_SEL_HIGH)) ##1 (s_access and pready);
  endsequence

  sequence s_write_ctrl;
    s_setup ##1 (s_access and (pwrite && paddr == ADDR_CTRL)) ##1 (s_access and pready);
  endsequence

  sequence s_write_mask;
    s_setup ##1 (s_access and (pwrite && paddr == ADDR_IRQ_MASK)) ##1 (s_access and pready);
  endsequence

  a_apb_one_wait: assert property (
    (s_setup ##1 s_access) |-> (!pready ##1 pready))
    else $error("apb answer not after exactly one wait state");

  a_fixed_nmi_line: assert property (
    1'b1 |=> (core_irq[1] == $past(nmi_event)) && (core_irq[3:2] == 2'b00))
    else $error("fixed lines not hard-wired");

  a_gie_gates_lines: assert property (
    !q.global_irq_enable |=> (core_irq[15:4] == 12'h000))
    else $error("maskable line active with global enable off");

  a_line_follows_sel: assert property (
    1'b1 |=> (core_irq[15:4] == ($past(line_src) & {NUM_SEL{$past(q.global_irq_enable)}})))
    else $error("maskable line does not follow its selected source");

  a_reserved_code_quiet: assert property (
    iss_code_reserved(sel_code[0]) |=> !core_irq[4])
    else $error("reserved code drove line 4");

  a_sel_high_write: assert property (
    s_write_hi |=> (q.sel_hi == ($past(pwdata) & SEL_WMASK)))
    else $error("high selector did not take the write");

  a_sel_low_write: assert property (
    s_write_lo |=> (q.sel_lo == ($past(pwdata) & SEL_WMASK)))
    else $error("low selector did not take the write");

  a_reset_defaults: assert property (
    $rose(presetn) |-> (q.sel_hi == SEL_HIGH_RST) && (q.sel_lo == SEL_LOW_RST) && !q.global_irq_enable)
    else $error("selector defaults wrong after reset");

  a_status_sticky: assert property (
    1'b1 |=> ((q.status & $past(q.status) & ~$past(clr)) == ($past(q.status) & ~$past(clr))))
    else $error("status bit lost without a clear");

  a_status_set_wins: assert property (
    (line_src[0] && clr[0]) |=> q.status[0])
    else $error("clear beat a simultaneous set");

  a_irq_level: assert property (
    1'b1 |=> (irq == |($past(d.status) & $past(d.mask))))
    else $error("irq does not match unmasked status");

  a_sel_high_read: assert property (
    s_read_hi |-> (prdata == $past(q.sel_hi)))
    else $error("high selector read back wrong");

  a_gie_write: assert property (
    s_write_ctrl |=> (q.global_irq_enable == $past(pwdata[CTRL_GIE_BIT])))
    else $error("global enable did not take the write");

  a_mask_write: assert property (
    s_write_mask |=> (q.mask == $past(pwdata[11:0])))
    else $error("mask did not take the write");

  a_reset_line: assert property (
    1'b1 |=> (core_irq[0] == $past(reset_event)))
    else $error("reset line not hard-wired");

  a_pready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("error response without pready");

  a_status_clear: assert property (
    (clr[10] && !line_src[10]) |=> !q.status[10])
    else $error("write one did not clear status");

  a_host_line: assert property (
    (sel_code[9] == CODE_HOST && q.global_irq_enable) |=> (core_irq[13] == $past(host_port_event)))
    else $error("host event not routed to its line");

  a_gp0_route: assert property (
    (sel_code[1] == CODE_GP0 && q.global_irq_enable) |=> (core_irq[5] == $past(gp.combined_irq)))
    else $error("combined gpio irq not routed to its line");
endmodule : iss_top
`default_nettype wire

// >>> test/iss_src_model.sv
/*
  peripheral event sources and gpio pads facing the selector.
  assumes the bench changes its requests just after a rising pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module iss_src_model (
  // requests from the bench, indexed by selector code
  input  wire logic [31:0] level,
  input  wire logic [15:0] pad_req,
  // lines into the selector
  output logic      [31:0] evt,
  output logic      [15:0] pads
);
  // each module raises only its own event; reserved and gpio codes stay low
  assign evt  = level & 32'hf0c0_ff0f;
  assign pads = pad_req;
endmodule : iss_src_model
`default_nettype wire

// >>> test/iss_top_test.sv
/*
  self-checking bench of the interrupt source selector.
  assumes one-wait-state APB answers and registered core lines.
*/
`timescale 1ns/1ps
`default_nettype none
module iss_top_test;
  import iss_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reset_event = 1'b0;
  logic        nmi_event = 1'b0;
  logic [31:0] level = 32'h0;
  logic [15:0] pad_req = 16'h0;
  logic [31:0] evt;
  logic [15:0] pads;
  logic [15:0] core_irq;
  logic        irq;
  logic        look = 1'b0;
  logic [33:0] lv;
  logic [32:0] rd_q[$];
  logic [33:0] ln_q[$];
  logic [31:0] sh[2];
  int          num_errors = 0;
  int          comparisons = 0;
  int          seed = 32'ha9e2;
  int          l;

  always #50 pclk = ~pclk;

  iss_src_model iss_src_model_i (.level(level), .pad_req(pad_req), .evt(evt), .pads(pads));
  iss_top iss_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_event(reset_event), .nmi_event(nmi_event),
    .host_port_event(evt[0]), .timer0_event(evt[1]), .timer1_event(evt[2]),
    .memif_event(evt[3]), .dma_done_event(evt[8]), .emu_transfer_event(evt[9]),
    .emu_rx_event(evt[10]), .emu_tx_event(evt[11]), .bsp0_tx_event(evt[12]),
    .bsp0_rx_event(evt[13]), .bsp1_tx_event(evt[14]), .bsp1_rx_event(evt[15]),
    .twowire0_event(evt[22]), .twowire1_event(evt[23]), .asp0_tx_event(evt[28]),
    .asp0_rx_event(evt[29]), .asp1_tx_event(evt[30]), .asp1_rx_event(evt[31]),
    .gpio_pins(pads), .core_irq(core_irq), .irq(irq));

  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // one apb transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    if (!w) rd_q.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // note expected {irq, core_irq} under a mask, n edges after stimulus
  task automatic see(input int n, input logic [16:0] m, input logic [16:0] v);
    repeat (n) @(posedge pclk);
    ln_q.push_back({m, v});
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask : see

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      cmp({pslverr, prdata}, rd_q.pop_front());
    if (look && ln_q.size() > 0) begin
      lv = ln_q.pop_front();
      cmp({16'h0, {irq, core_irq} & lv[33:17]}, {16'h0, lv[16:0]});
    end
  end

  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    sh[0] = SEL_LOW_RST;
    sh[1] = SEL_HIGH_RST;
    apb(1'b0, ADDR_SEL_HIGH, 32'h0, {1'b0, 32'h0820_2d43});
    apb(1'b0, ADDR_SEL_LOW, 32'h0, {1'b0, 32'h2507_18a4});
    apb(1'b0, ADDR_SEL_HIGH + 32'h40, 32'h0, {1'b1, 32'h0});
    level <= 32'h2;
    reset_event <= 1'b1;
    nmi_event <= 1'b1;
    see(1, 17'h1_ffff, 17'h0_0003);
    level <= 32'h0;
    reset_event <= 1'b0;
    nmi_event <= 1'b0;
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, {1'b0, 32'h400});
    apb(1'b1, ADDR_IRQ_MASK, 32'h400, 33'h0);
    see(1, 17'h1_0000, 17'h1_0000);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h400, 33'h0);
    see(1, 17'h1_0000, 17'h0);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, 33'h0);
    apb(1'b1, ADDR_SEL_LOW, 32'hffff_ffff, 33'h0);
    apb(1'b0, ADDR_SEL_LOW, 32'h0, {1'b0, 32'h7fff_7fff});
    apb(1'b1, ADDR_SEL_LOW, SEL_LOW_RST, 33'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0f01, 33'h0);
    for (int c = 0; c < 32; c++) begin
      if ((c >= 4 && c <= 7) || c == 16) continue;
      l = 4 + ($unsigned($random(seed)) % 12);
      sh[l >= 10][SEL_LSB[(l - 4) % 6] +: 5] = c[4:0];
      apb(1'b1, (l >= 10) ? ADDR_SEL_HIGH : ADDR_SEL_LOW, sh[l >= 10], 33'h0);
      level <= iss_code_reserved(c[4:0]) ? 32'hffff_ffff : (32'h1 << c);
      see(1, 17'h1 << l, iss_code_reserved(c[4:0]) ? 17'h0 : (17'h1 << l));
      level <= 32'h0;
    end
    sh[0] = SEL_LOW_RST;
    sh[0][9:5] = 5'h10;
    apb(1'b1, ADDR_SEL_LOW, sh[0], 33'h0);
    apb(1'b1, ADDR_GPIO_CFG, 32'h0000_0110, 33'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0f11, 33'h0);
    pad_req <= 16'h0010;
    see(2, 17'h0_0030, 17'h0);
    pad_req <= 16'h0100;
    see(2, 17'h0_0030, 17'h0_0030);
    see(1, 17'h0_0030, 17'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0f01, 33'h0);
    pad_req <= 16'h0010;
    see(2, 17'h0_0030, 17'h0_0010);
    pad_req <= 16'h0000;
    apb(1'b1, ADDR_GPIO_CFG, 32'h0010_0110, 33'h0);
    pad_req <= 16'h0010;
    see(2, 17'h0_0030, 17'h0);
    pad_req <= 16'h0000;
    apb(1'b1, ADDR_GPIO_CFG, 32'h0000_0110, 33'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001, 33'h0);
    pad_req <= 16'h0010;
    see(2, 17'h0_0030, 17'h0_0020);
    give_verdict();
  end
endmodule : iss_top_test
`default_nettype wire
